// ---- shared/psc_pkg.sv ----
package psc_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CAP = 8'h04;
  localparam logic [7:0] OFF_OVR = 8'h08;
  localparam logic [7:0] OFF_DLY1 = 8'h0C;
  localparam logic [7:0] OFF_DLY2 = 8'h10;
  localparam logic [7:0] OFF_DLY3 = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam int CTRL_W = 8;
  localparam int B_METHOD = 0;
  localparam int B_HOME_DIS = 1;
  localparam int B_DEAD_DIS = 2;
  localparam int B_SAFE_SEL = 3;
  localparam int B_PSAVE = 4;
  localparam int B_DSEL_LO = 5;
  localparam int B_DSEL_HI = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h04;
  localparam logic [7:0] CAP_MIN = 8'h01;
  localparam logic [7:0] CAP_MAX = 8'hFA;
  localparam logic [7:0] CAP_RST = 8'h64;
  localparam logic [6:0] OVR_MIN = 7'h01;
  localparam logic [6:0] OVR_MAX = 7'h64;
  localparam logic [6:0] OVR_RST = 7'h64;
  localparam int DLY_W = 14;
  localparam logic [DLY_W-1:0] DLY_MAX = 14'h270F;
  localparam logic [DLY_W-1:0] DLY_RST = 14'h0000;
  localparam int VEL_W = 16;
  localparam int NUM_W = 7;
  localparam int CLK_HZ = 40000000;
  localparam int SEC_S = 1;
  localparam int SEC_CYCLES = SEC_S * CLK_HZ;
  typedef enum logic [1:0] {
    PSC_T_IDLE = 2'b00,
    PSC_T_COUNT = 2'b01,
    PSC_T_OFF = 2'b10
  } psc_tmr_t;
endpackage : psc_pkg

// ---- rtl/psc_sync.sv ----
`timescale 1ns/1ps
module psc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : psc_sync

// ---- rtl/psc_servo_timer.sv ----
`timescale 1ns/1ps
module psc_servo_timer #(
  parameter int SEC_CYCLES = psc_pkg::SEC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic cancel,
  input wire logic [psc_pkg::DLY_W-1:0] delay_s,
  output logic servo_off_q
);
  psc_pkg::psc_tmr_t st_q;
  logic [31:0] pre_q;
  logic [psc_pkg::DLY_W-1:0] sec_q;
  // Counts whole seconds after completion, then holds servo off until cancelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= psc_pkg::PSC_T_IDLE;
      pre_q <= '0;
      sec_q <= '0;
      servo_off_q <= 1'b0;
    end else if (cancel) begin
      st_q <= psc_pkg::PSC_T_IDLE;
      servo_off_q <= 1'b0;
    end else begin
      case (st_q)
        psc_pkg::PSC_T_IDLE: begin
          pre_q <= '0;
          sec_q <= '0;
          if (start) begin
            st_q <= psc_pkg::PSC_T_COUNT;
          end
        end
        psc_pkg::PSC_T_COUNT: begin
          if (sec_q >= delay_s) begin
            st_q <= psc_pkg::PSC_T_OFF;
            servo_off_q <= 1'b1;
          end else if (pre_q == 32'(SEC_CYCLES - 1)) begin
            pre_q <= '0;
            sec_q <= sec_q + 1'b1;
          end else begin
            pre_q <= pre_q + 1'b1;
          end
        end
        psc_pkg::PSC_T_OFF: servo_off_q <= 1'b1;
        default: st_q <= psc_pkg::PSC_T_IDLE;
      endcase
    end
  end

  servo_off_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(servo_off_q) |-> !$past(cancel) && $past(st_q) == psc_pkg::PSC_T_COUNT && $past(sec_q) >= $past(delay_s))
    else $error("servo off without elapsed delay");
endmodule : psc_servo_timer

// ---- rtl/psc_top.sv ----
`timescale 1ns/1ps
// How it works
// - With safety speed selected, manual speed is capped at 1..250, default 100.
// - With power saving on, servo turns off a chosen 0..9999 s after completion.
// - Method bit 0 gives latched completion, 1 gives live in-window; default 0.
// - Method bit only applies when no solenoid-valve pattern is active.
// - Latched completion sets on completion and ignores later window exits.
// - Latched completion drops during any pause and while servo is off.
// - In-window mode follows whether the position lies inside the width.
// - Done and current position numbers follow the same selected behaviour.
// - Home-return input honoured when its disable bit is 0, ignored at 1.
// - Deadman input used when its disable bit is 0, ignored at 1; default 1.
// - PLC moves run at table velocity times override percent, default 100.
// - Override steps by one percent, clamped to 1..100.
// - Teaching tool moves ignore the override.
module psc_top #(
  parameter int SEC_CYCLES = psc_pkg::SEC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pos_done,
  input wire logic in_window,
  input wire logic move_start,
  input wire logic paused,
  input wire logic servo_on,
  input wire logic solenoid_pattern,
  input wire logic [psc_pkg::NUM_W-1:0] target_num,
  input wire logic [psc_pkg::VEL_W-1:0] table_velocity,
  input wire logic from_plc,
  input wire logic manual_op,
  input wire logic home_in,
  input wire logic deadman_in,
  output logic positioning_done_out,
  output logic [psc_pkg::NUM_W-1:0] done_position_number_out,
  output logic [psc_pkg::NUM_W-1:0] current_position_number_out,
  output logic [psc_pkg::VEL_W-1:0] cmd_velocity,
  output logic servo_off_req,
  output logic home_req,
  output logic deadman_ok
);
  logic [psc_pkg::CTRL_W-1:0] ctrl_q;
  logic [7:0] manual_speed_cap_q;
  logic [6:0] speed_override_percent_q;
  logic [psc_pkg::DLY_W-1:0] servo_off_delay_one_q;
  logic [psc_pkg::DLY_W-1:0] servo_off_delay_two_q;
  logic [psc_pkg::DLY_W-1:0] servo_off_delay_three_q;
  logic [psc_pkg::DLY_W-1:0] dly_sel;
  logic [1:0] pins_s;
  logic acc, wr, rd_setup, mapped;
  logic [31:0] rd_d;
  logic live_mode;
  logic latched_done_flag_q;
  logic [psc_pkg::NUM_W-1:0] latched_num_q;
  logic [psc_pkg::VEL_W+6:0] prod;
  logic [psc_pkg::VEL_W-1:0] scaled, vel_d;
  logic [7:0] cap_w;
  logic [6:0] ovr_w;
  logic [psc_pkg::DLY_W-1:0] dly_w;
  logic tmr_off;
  logic done_d;
  logic [psc_pkg::NUM_W-1:0] done_num_d, cur_num_d;

  psc_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({home_in, deadman_in}),
    .q(pins_s)
  );

  // APB: one wait state, answer on the second access cycle
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd_setup = psel && penable && !pready;
  always_comb begin
    mapped = 1'b1;
    rd_d = '0;
    case (paddr)
      psc_pkg::OFF_CTRL: rd_d = 32'(ctrl_q);
      psc_pkg::OFF_CAP: rd_d = 32'(manual_speed_cap_q);
      psc_pkg::OFF_OVR: rd_d = 32'(speed_override_percent_q);
      psc_pkg::OFF_DLY1: rd_d = 32'(servo_off_delay_one_q);
      psc_pkg::OFF_DLY2: rd_d = 32'(servo_off_delay_two_q);
      psc_pkg::OFF_DLY3: rd_d = 32'(servo_off_delay_three_q);
      psc_pkg::OFF_STAT: rd_d = {24'h000000, deadman_ok, home_req, servo_off_req, done_position_number_out[5:0] == 6'h00,
                                 live_mode, latched_done_flag_q, in_window, positioning_done_out};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup && !mapped;
      prdata <= (rd_setup && !pwrite) ? rd_d : '0;
    end
  end

  // Write values clamped into their legal ranges
  always_comb begin
    cap_w = pwdata[7:0];
    if (pwdata[31:8] != 24'h000000 || cap_w > psc_pkg::CAP_MAX) begin
      cap_w = psc_pkg::CAP_MAX;
    end else if (cap_w < psc_pkg::CAP_MIN) begin
      cap_w = psc_pkg::CAP_MIN;
    end
    ovr_w = pwdata[6:0];
    if (pwdata[31:7] != 25'h0000000 || ovr_w > psc_pkg::OVR_MAX) begin
      ovr_w = psc_pkg::OVR_MAX;
    end else if (ovr_w < psc_pkg::OVR_MIN) begin
      ovr_w = psc_pkg::OVR_MIN;
    end
    dly_w = pwdata[psc_pkg::DLY_W-1:0];
    if (pwdata[31:psc_pkg::DLY_W] != 18'h00000 || dly_w > psc_pkg::DLY_MAX) begin
      dly_w = psc_pkg::DLY_MAX;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= psc_pkg::CTRL_RST;
      manual_speed_cap_q <= psc_pkg::CAP_RST;
      speed_override_percent_q <= psc_pkg::OVR_RST;
      servo_off_delay_one_q <= psc_pkg::DLY_RST;
      servo_off_delay_two_q <= psc_pkg::DLY_RST;
      servo_off_delay_three_q <= psc_pkg::DLY_RST;
    end else if (wr) begin
      case (paddr)
        psc_pkg::OFF_CTRL: ctrl_q <= pwdata[psc_pkg::CTRL_W-1:0];
        psc_pkg::OFF_CAP: manual_speed_cap_q <= cap_w;
        psc_pkg::OFF_OVR: speed_override_percent_q <= ovr_w;
        psc_pkg::OFF_DLY1: servo_off_delay_one_q <= dly_w;
        psc_pkg::OFF_DLY2: servo_off_delay_two_q <= dly_w;
        psc_pkg::OFF_DLY3: servo_off_delay_three_q <= dly_w;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Completion method, forced latched while a solenoid pattern runs
  assign live_mode = ctrl_q[psc_pkg::B_METHOD] && !solenoid_pattern;

  // Latched completion flag; pause and servo-off clear with priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_done_flag_q <= 1'b0;
      latched_num_q <= '0;
    end else if (paused || !servo_on) begin
      latched_done_flag_q <= 1'b0;
    end else if (pos_done) begin
      latched_done_flag_q <= 1'b1;
      latched_num_q <= target_num;
    end else if (move_start) begin
      latched_done_flag_q <= 1'b0;
    end
  end

  always_comb begin
    if (live_mode) begin
      done_d = in_window;
      done_num_d = in_window ? target_num : '0;
      cur_num_d = in_window ? target_num : '0;
    end else begin
      done_d = latched_done_flag_q;
      done_num_d = latched_done_flag_q ? latched_num_q : '0;
      cur_num_d = latched_done_flag_q ? latched_num_q : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      positioning_done_out <= 1'b0;
      done_position_number_out <= '0;
      current_position_number_out <= '0;
    end else begin
      positioning_done_out <= done_d;
      done_position_number_out <= done_num_d;
      current_position_number_out <= cur_num_d;
    end
  end

  // Velocity: override only for PLC moves, cap for manual safety speed
  assign prod = table_velocity * speed_override_percent_q;
  assign scaled = psc_pkg::VEL_W'(prod / 7'(psc_pkg::OVR_MAX));
  always_comb begin
    vel_d = from_plc ? scaled : table_velocity;
    if (manual_op && ctrl_q[psc_pkg::B_SAFE_SEL] && vel_d > 16'(manual_speed_cap_q)) begin
      vel_d = 16'(manual_speed_cap_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_velocity <= '0;
    end else begin
      cmd_velocity <= vel_d;
    end
  end

  // Input gating for home return and deadman switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      home_req <= 1'b0;
      deadman_ok <= 1'b1;
    end else begin
      home_req <= pins_s[1] && !ctrl_q[psc_pkg::B_HOME_DIS];
      deadman_ok <= pins_s[0] || ctrl_q[psc_pkg::B_DEAD_DIS];
    end
  end

  // Auto servo-off delay, one of three settings
  always_comb begin
    case (ctrl_q[psc_pkg::B_DSEL_HI:psc_pkg::B_DSEL_LO])
      2'h1: dly_sel = servo_off_delay_two_q;
      2'h2: dly_sel = servo_off_delay_three_q;
      default: dly_sel = servo_off_delay_one_q;
    endcase
  end

  psc_servo_timer #(.SEC_CYCLES(SEC_CYCLES)) u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(pos_done && ctrl_q[psc_pkg::B_PSAVE]),
    .cancel(move_start || !ctrl_q[psc_pkg::B_PSAVE]),
    .delay_s(dly_sel),
    .servo_off_q(tmr_off)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_off_req <= 1'b0;
    end else begin
      servo_off_req <= tmr_off;
    end
  end

  safety_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    manual_op && ctrl_q[psc_pkg::B_SAFE_SEL] |=> cmd_velocity <= 16'($past(manual_speed_cap_q)))
    else $error("manual speed above cap");
  cap_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    manual_speed_cap_q >= psc_pkg::CAP_MIN && manual_speed_cap_q <= psc_pkg::CAP_MAX)
    else $error("speed cap out of range");
  latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !live_mode && pos_done && servo_on && !paused ##1 !live_mode && !paused && servo_on && !move_start
    |=> positioning_done_out)
    else $error("latched completion not held");
  latch_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !live_mode && (paused || !servo_on) |=> ##1 !positioning_done_out)
    else $error("completion high during pause or servo off");
  live_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    live_mode |=> positioning_done_out == $past(in_window))
    else $error("in-window output mismatch");
  pattern_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    solenoid_pattern |-> !live_mode)
    else $error("method applied under solenoid pattern");
  num_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    !positioning_done_out |-> done_position_number_out == '0 && current_position_number_out == '0)
    else $error("position number without completion");
  home_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[psc_pkg::B_HOME_DIS] |=> !home_req)
    else $error("home input not ignored");
  deadman_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[psc_pkg::B_DEAD_DIS] |=> deadman_ok)
    else $error("deadman input not ignored");
  override_a: assert property (@(posedge pclk) disable iff (!presetn)
    from_plc && !manual_op |=> 32'(cmd_velocity) * 32'd100 <= 32'($past(table_velocity)) * 32'($past(speed_override_percent_q))
    && (32'(cmd_velocity) + 32'd1) * 32'd100 > 32'($past(table_velocity)) * 32'($past(speed_override_percent_q)))
    else $error("override product wrong");
  ovr_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    speed_override_percent_q >= psc_pkg::OVR_MIN && speed_override_percent_q <= psc_pkg::OVR_MAX)
    else $error("override out of range");
  tool_unscaled_a: assert property (@(posedge pclk) disable iff (!presetn)
    !from_plc && !manual_op |=> cmd_velocity == $past(table_velocity))
    else $error("override applied to tool move");
endmodule : psc_top

// ---- sim/psc_plc_model.sv ----
`timescale 1ns/1ps
module psc_plc_model (
  input wire logic pclk,
  output logic pos_done,
  output logic in_window,
  output logic move_start,
  output logic paused,
  output logic servo_on,
  output logic solenoid_pattern,
  output logic [psc_pkg::NUM_W-1:0] target_num,
  output logic [psc_pkg::VEL_W-1:0] table_velocity,
  output logic from_plc,
  output logic manual_op,
  output logic home_in,
  output logic deadman_in
);
  initial begin
    {pos_done, in_window, move_start, paused} = 4'h0;
    {solenoid_pattern, manual_op, home_in, deadman_in} = 4'h0;
    servo_on = 1'b1;
    from_plc = 1'b1;
    target_num = 7'h00;
    table_velocity = 16'h0000;
  end
  // Completion pulse; the number moves on afterwards so a stale capture shows
  task automatic finish_move(input logic [psc_pkg::NUM_W-1:0] num);
    target_num <= num;
    pos_done <= 1'b1;
    @(posedge pclk);
    pos_done <= 1'b0;
    target_num <= ~num;
  endtask : finish_move
  task automatic start_move();
    move_start <= 1'b1;
    @(posedge pclk);
    move_start <= 1'b0;
  endtask : start_move
  task automatic set_state(input logic srv, input logic pau, input logic inw, input logic sol);
    servo_on <= srv;
    paused <= pau;
    in_window <= inw;
    solenoid_pattern <= sol;
  endtask : set_state
  task automatic set_target(input logic [psc_pkg::NUM_W-1:0] num);
    target_num <= num;
  endtask : set_target
  task automatic set_move(input logic [15:0] vel, input logic plc, input logic man);
    table_velocity <= vel;
    from_plc <= plc;
    manual_op <= man;
  endtask : set_move
  task automatic set_pins(input logic h, input logic d);
    home_in <= h;
    deadman_in <= d;
  endtask : set_pins
endmodule : psc_plc_model

// ---- sim/tb_psc_top.sv ----
`timescale 1ns/1ps
module tb_psc_top;
  localparam int SECS = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
  logic [7:0] paddr, ctrl_v, cap_v;
  logic [31:0] pwdata, prdata, rdv, seed, rv;
  logic [6:0] ovr_v, dnum, cnum;
  logic [15:0] cmd_velocity, tv;
  logic pos_done, in_window, move_start, paused, servo_on, solenoid_pattern, from_plc, manual_op;
  logic home_in, deadman_in, positioning_done_out, servo_off_req, home_req, deadman_ok;
  logic [6:0] target_num;
  logic [15:0] table_velocity;
  logic [3:0] kb;
  int bad_count, compares, n, lim;
  psc_top #(.SEC_CYCLES(SECS)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pos_done(pos_done), .in_window(in_window), .move_start(move_start), .paused(paused),
    .servo_on(servo_on), .solenoid_pattern(solenoid_pattern), .target_num(target_num),
    .table_velocity(table_velocity), .from_plc(from_plc), .manual_op(manual_op), .home_in(home_in),
    .deadman_in(deadman_in), .positioning_done_out(positioning_done_out),
    .done_position_number_out(dnum), .current_position_number_out(cnum), .cmd_velocity(cmd_velocity),
    .servo_off_req(servo_off_req), .home_req(home_req), .deadman_ok(deadman_ok));
  psc_plc_model u_plc (.pclk(pclk), .pos_done(pos_done), .in_window(in_window), .move_start(move_start),
    .paused(paused), .servo_on(servo_on), .solenoid_pattern(solenoid_pattern), .target_num(target_num),
    .table_velocity(table_velocity), .from_plc(from_plc), .manual_op(manual_op), .home_in(home_in),
    .deadman_in(deadman_in));
  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chk_flag
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] exp_vel(input logic [15:0] t, input logic plc, input logic man);
    logic [31:0] v;
    v = plc ? (32'(t) * 32'(ovr_v)) / 32'h64 : 32'(t);
    return (man && ctrl_v[psc_pkg::B_SAFE_SEL] && v > 32'(cap_v)) ? 32'(cap_v) : v;
  endfunction : exp_vel
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    bad_count += (k >= 100);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_val(rdv, exp);
  endtask : rdc
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    apb(1'b1, a, d);
    rdc(a, exp);
  endtask : wrc
  task automatic look(input logic d, input logic [6:0] num);
    repeat (3) @(posedge pclk);
    #1;
    chk_flag(positioning_done_out, d);
    chk_val({25'h0, dnum}, {25'h0, num});
    chk_val({25'h0, cnum}, {25'h0, num});
    @(posedge pclk);
  endtask : look
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #250000;
    bad_count++;
    end_sim();
  end
  initial begin
    seed = 32'h974B7400;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(psc_pkg::OFF_CTRL, 32'h4);
    rdc(psc_pkg::OFF_CAP, 32'h64);
    rdc(psc_pkg::OFF_OVR, 32'h64);
    for (int k = 0; k < 3; k++) rdc(psc_pkg::OFF_DLY1 + 8'(4 * k), 32'h0);
    chk_flag(deadman_ok, 1'b1);
    apb(1'b1, 8'h1C, 32'hFF);
    chk_flag(erv, 1'b1);
    rdc(8'h1C, 32'h0);
    chk_flag(erv, 1'b1);
    rdc(psc_pkg::OFF_CTRL, 32'h4);
    wrc(psc_pkg::OFF_CAP, 32'h0, 32'h1);
    wrc(psc_pkg::OFF_CAP, 32'h12C, 32'hFA);
    wrc(psc_pkg::OFF_OVR, 32'h0, 32'h1);
    wrc(psc_pkg::OFF_OVR, 32'hC8, 32'h64);
    wrc(psc_pkg::OFF_DLY3, 32'h2710, 32'h270F);
    for (int i = 0; i < 24; i++) begin
      rv = rnd();
      ovr_v = (i == 0) ? 7'h01 : (i == 1) ? 7'h64 : 7'(rv % 100 + 1);
      cap_v = 8'(rnd() % 250 + 1);
      ctrl_v = {4'h0, rv[3], 3'h4};
      tv = (i < 2) ? 16'hFFFF : rv[31:16];
      apb(1'b1, psc_pkg::OFF_OVR, {25'h0, ovr_v});
      apb(1'b1, psc_pkg::OFF_CAP, {24'h0, cap_v});
      apb(1'b1, psc_pkg::OFF_CTRL, {24'h0, ctrl_v});
      u_plc.set_move(tv, rv[4] | (i < 2), rv[5]);
      repeat (2) @(posedge pclk);
      #1;
      chk_val({16'h0, cmd_velocity}, exp_vel(tv, rv[4] | (i < 2), rv[5]));
      @(posedge pclk);
    end
    apb(1'b1, psc_pkg::OFF_CTRL, 32'h4);
    u_plc.set_state(1'b1, 1'b0, 1'b1, 1'b0);
    u_plc.finish_move(7'h2A);
    u_plc.set_state(1'b1, 1'b0, 1'b0, 1'b0);
    look(1'b1, 7'h2A);
    u_plc.set_state(1'b1, 1'b1, 1'b0, 1'b0);
    look(1'b0, 7'h00);
    u_plc.set_state(1'b1, 1'b0, 1'b0, 1'b0);
    u_plc.finish_move(7'h55);
    look(1'b1, 7'h55);
    u_plc.set_state(1'b0, 1'b0, 1'b0, 1'b0);
    look(1'b0, 7'h00);
    apb(1'b1, psc_pkg::OFF_CTRL, 32'h5);
    u_plc.set_state(1'b1, 1'b0, 1'b0, 1'b1);
    u_plc.finish_move(7'h0C);
    look(1'b1, 7'h0C);
    u_plc.set_state(1'b1, 1'b0, 1'b0, 1'b0);
    look(1'b0, 7'h00);
    u_plc.set_state(1'b1, 1'b0, 1'b1, 1'b0);
    u_plc.set_target(7'h15);
    look(1'b1, 7'h15);
    rdc(psc_pkg::OFF_STAT, 32'h8F);
    for (int i = 0; i < 16; i++) begin
      rv = rnd();
      u_plc.set_state(1'b1, rv[1], rv[0], 1'b0);
      u_plc.set_target(rv[14:8]);
      repeat (2) @(posedge pclk);
      #1;
      chk_flag(positioning_done_out, rv[0]);
      chk_val({25'h0, dnum}, {25'h0, rv[0] ? rv[14:8] : 7'h00});
      chk_val({25'h0, cnum}, {25'h0, rv[0] ? rv[14:8] : 7'h00});
      @(posedge pclk);
    end
    u_plc.set_state(1'b1, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++) apb(1'b1, psc_pkg::OFF_DLY1 + 8'(4 * k), 32'(k + 1));
    for (int k = 0; k < 4; k++) begin
      if (k == 3) begin
        apb(1'b1, psc_pkg::OFF_DLY1, 32'h0);
      end
      apb(1'b1, psc_pkg::OFF_CTRL, {24'h0, 1'b0, 2'(k), 1'b1, 4'h4});
      u_plc.start_move();
      repeat (3) @(posedge pclk);
      chk_flag(servo_off_req, 1'b0);
      u_plc.finish_move(7'h01);
      n = 1;
      while (servo_off_req !== 1'b1 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      lim = (k == 3) ? 0 : (k + 1) * SECS;
      chk_flag(n >= lim && n <= lim + 4, 1'b1);
    end
    apb(1'b1, psc_pkg::OFF_CTRL, 32'h4);
    u_plc.finish_move(7'h01);
    repeat (6) @(posedge pclk);
    chk_flag(servo_off_req, 1'b0);
    for (int k = 0; k < 16; k++) begin
      kb = 4'(k);
      apb(1'b1, psc_pkg::OFF_CTRL, {29'h0, kb[3], kb[2], 1'b0});
      u_plc.set_pins(kb[0], kb[1]);
      repeat (5) @(posedge pclk);
      #1;
      chk_flag(home_req, kb[0] & ~kb[2]);
      chk_flag(deadman_ok, kb[3] | kb[1]);
      @(posedge pclk);
    end
    end_sim();
  end
endmodule : tb_psc_top
